//--- logic/hmcb_consts.svh
// constants for the host misc csr bank: offsets, fields, reset values, timing
// assumes a 16-bit host bus with A[1] selecting the half-word of a 32-bit register
// Operation
// RQ1: timer count field reads the live 16-bit timer value, all ones after reset.
// RQ2: timer count starts from the programmed 16-bit preload value.
// RQ3: word order other than all ones: A[1]=1 upper half, A[1]=0 lower half.
// RQ4: word order all ones: A[1]=1 lower half, A[1]=0 upper half.
// RQ5: fifo network side always lower word first, independent of word order.
// RQ6: 32-bit free counter from zero, plus one per 25 MHz tick, wraps.
// RQ7: first half-word read latches the full free count for the second read.
// RQ8: free counter is cleared within 160 ns of a reset event.
// RQ9: free counter counts in every power management state.
// RQ10: discard counter adds one per dropped receive frame, resets to zero.
// RQ11: reading the discard register returns the count then clears it.
// RQ12: event when discard counter msb goes from zero to one.
// RQ13: writing one to busy starts indirect access; device clears busy when done.
// RQ14: indirect read data lands in the data register before busy clears.
// RQ15: host leaves command and data registers alone while busy is set.
// RQ16: direction bit one means read, zero means write; resets to zero.
// RQ17: 8-bit address field in the command register selects the mac register.
// RQ18: 32-bit indirect data register holds write or read value, resets zero.
// RQ19: reserved bits read zero and ignore writes.
`ifndef HMCB_CONSTS_SVH
`define HMCB_CONSTS_SVH
`define HMCB_ADDR_W 8
`define HMCB_OFF_TIMER_COUNT 8'h90
`define HMCB_OFF_WORD_ORDER 8'h98
`define HMCB_OFF_FREE_TICK 8'h9c
`define HMCB_OFF_RX_DISCARD 8'ha0
`define HMCB_OFF_MAC_CMD 8'ha4
`define HMCB_OFF_MAC_DATA 8'ha8
`define HMCB_WORD_MASK 8'hfc
`define HMCB_HALF_BIT 1
`define HMCB_SWAP_ALL_ONES 32'hffffffff
`define HMCB_RST_WORD_ORDER 32'h00000000
`define HMCB_RST_TIMER 16'hffff
`define HMCB_RST_ZERO32 32'h00000000
`define HMCB_RST_ADDR8 8'h00
`define HMCB_CMD_BUSY 31
`define HMCB_CMD_DIR 30
`define HMCB_CMD_ADDR_HI 7
`define HMCB_MSB 31
`define HMCB_ONE32 32'h00000001
`define HMCB_ONE16 16'h0001
`define HMCB_ZERO16 16'h0000
`define HMCB_CLK_MHZ 25
`define HMCB_FREE_CLEAR_NS 160
`define HMCB_FREE_CLEAR_CYC ((`HMCB_FREE_CLEAR_NS * `HMCB_CLK_MHZ) / 1000)
`endif

//--- logic/hmcb_pkg.sv
// types for the host misc csr bank
// assumes hmcb_consts.svh is on the include path
package hmcb_pkg;
	typedef enum logic [2:0] {
		HMCB_IDLE = 3'b001,
		HMCB_ISSUE = 3'b010,
		HMCB_WAIT = 3'b100
	} hmcb_ind_state_t;
endpackage

//--- logic/hmcb_free_counter.sv
// free-running 32-bit tick counter with a half-word read latch
// assumes clk is the 25 MHz tick and a read strobe lasts one cycle
`timescale 1ns/1ps
`include "hmcb_consts.svh"
module hmcb_free_counter (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic rd_lo,
	input wire logic rd_hi,
	output logic [31:0] live,
	output logic [31:0] snap
);
	logic [31:0] cnt_q, cnt_d;
	logic [31:0] snap_q, snap_d;
	logic first_q, first_d;
	// count and latch; no power-state gating on purpose, it must always run
	always_comb begin
		cnt_d = cnt_q + `HMCB_ONE32; // see RQ6 see RQ9
		snap_d = snap_q;
		first_d = first_q;
		if ((rd_lo || rd_hi) && first_q) begin
			snap_d = cnt_q; // see RQ7
			first_d = 1'b0;
		end else if (rd_lo || rd_hi) begin
			first_d = 1'b1; // second half consumed the snapshot
		end
	end
	// async clear lands in zero cycles, far inside the clear window
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_q <= `HMCB_RST_ZERO32; // see RQ8
			snap_q <= `HMCB_RST_ZERO32;
			first_q <= 1'b1;
		end else begin
			cnt_q <= cnt_d;
			snap_q <= snap_d;
			first_q <= first_d;
		end
	end
	assign live = cnt_q;
	assign snap = first_q ? snap_d : snap_q;
endmodule

//--- logic/hmcb_host_misc_csr_bank.sv
// host-visible misc control/status registers on the 16-bit host bus
// assumes single-cycle read and write strobes, and a mac csr port that
// answers a request with a one-cycle done pulse
`timescale 1ns/1ps
`include "hmcb_consts.svh"
module hmcb_host_misc_csr_bank
	import hmcb_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] host_addr,
	input wire logic host_rd,
	input wire logic host_wr,
	input wire logic [15:0] host_wdata,
	output logic [15:0] host_rdata,
	output logic word_swap_upper,
	input wire logic [15:0] timer_preload_value,
	input wire logic timer_load,
	input wire logic timer_run,
	output logic timer_wrap,
	input wire logic rx_frame_dropped,
	output logic rx_discard_half_event,
	output logic mac_req,
	output logic mac_read_not_write,
	output logic [7:0] mac_addr,
	output logic [31:0] mac_wdata,
	input wire logic mac_done,
	input wire logic [31:0] mac_rdata,
	input wire logic [31:0] tx_fifo_entry,
	output logic [15:0] tx_net_word,
	input wire logic tx_word_sel,
	input wire logic [15:0] rx_net_word,
	input wire logic rx_first_word,
	input wire logic rx_word_valid,
	output logic [31:0] rx_fifo_entry
);
	// true when this half-word access reaches bits 31:16
	function automatic logic upper_half(input logic [7:0] a, input logic [31:0] order);
		upper_half = (order == `HMCB_SWAP_ALL_ONES) ? !a[`HMCB_HALF_BIT] : a[`HMCB_HALF_BIT];
	endfunction
	// register hit on the word-aligned address
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = ((a & `HMCB_WORD_MASK) == off);
	endfunction

	logic [31:0] order_q, order_d;
	logic [15:0] timer_q, timer_d;
	logic [31:0] drop_q, drop_d;
	logic drop_lo_pend_q, drop_lo_pend_d;
	logic [31:0] drop_snap_q, drop_snap_d;
	logic busy_q, busy_d;
	logic dir_q, dir_d;
	logic [7:0] caddr_q, caddr_d;
	logic [31:0] data_q, data_d;
	hmcb_ind_state_t st_q, st_d;
	logic [15:0] rdata_q, rdata_d;
	logic [15:0] txw_q, txw_d;
	logic [31:0] rxe_q, rxe_d;
	logic half_ev_q, half_ev_d;
	logic wrap_q, wrap_d;
	logic up;
	logic [31:0] free_snap;
	logic [31:0] wr_word;

	assign up = upper_half(host_addr, order_q); // see RQ3 see RQ4

	// free counter and its first-read latch
	hmcb_free_counter u_free (
		.clk(clk),
		.sys_rst(sys_rst),
		.rd_lo(host_rd && hit(host_addr, `HMCB_OFF_FREE_TICK) && !up),
		.rd_hi(host_rd && hit(host_addr, `HMCB_OFF_FREE_TICK) && up),
		.live(),
		.snap(free_snap)
	);

	// general timer: down count from preload, reload at underflow
	always_comb begin
		timer_d = timer_q;
		wrap_d = 1'b0;
		if (timer_load) begin
			timer_d = timer_preload_value; // see RQ2
		end else if (timer_run) begin
			if (timer_q == `HMCB_ZERO16) begin
				timer_d = timer_preload_value; // see RQ2
				wrap_d = 1'b1;
			end else begin
				timer_d = timer_q - `HMCB_ONE16;
			end
		end
	end

	// write data placed in the selected half of a 32-bit word
	always_comb begin
		wr_word = up ? {host_wdata, `HMCB_ZERO16} : {`HMCB_ZERO16, host_wdata};
	end

	// word order register takes whichever half is addressed
	always_comb begin
		order_d = order_q;
		if (host_wr && hit(host_addr, `HMCB_OFF_WORD_ORDER)) begin
			if (up) begin
				order_d[31:16] = host_wdata;
			end else begin
				order_d[15:0] = host_wdata;
			end
		end
	end

	// dropped-frame counter: first read of a pair, either half, clears; a drop in the same
	// cycle as the clearing read is kept by counting from zero
	always_comb begin
		drop_d = drop_q;
		drop_snap_d = drop_snap_q;
		drop_lo_pend_d = drop_lo_pend_q;
		half_ev_d = 1'b0;
		if (host_rd && hit(host_addr, `HMCB_OFF_RX_DISCARD)) begin
			if (!drop_lo_pend_q) begin
				drop_snap_d = drop_q; // first half latches the count
				drop_d = rx_frame_dropped ? `HMCB_ONE32 : `HMCB_RST_ZERO32; // see RQ11
			end else if (rx_frame_dropped) begin
				drop_d = drop_q + `HMCB_ONE32; // see RQ10
			end
			drop_lo_pend_d = !drop_lo_pend_q;
		end else if (rx_frame_dropped) begin
			drop_d = drop_q + `HMCB_ONE32; // see RQ10
		end
		if (!drop_q[`HMCB_MSB] && drop_d[`HMCB_MSB]) begin
			half_ev_d = 1'b1; // see RQ12
		end
	end

	// indirect mac access: command/data registers and sequencer
	always_comb begin
		busy_d = busy_q;
		dir_d = dir_q;
		caddr_d = caddr_q;
		data_d = data_q;
		st_d = st_q;
		// host writes; reserved command bits are simply not stored
		if (host_wr && hit(host_addr, `HMCB_OFF_MAC_CMD) && !busy_q) begin
			if (up) begin
				dir_d = wr_word[`HMCB_CMD_DIR]; // see RQ16
				busy_d = wr_word[`HMCB_CMD_BUSY]; // see RQ13
			end else begin
				caddr_d = wr_word[`HMCB_CMD_ADDR_HI:0]; // see RQ17 see RQ19
			end
		end
		// data changes during busy are dropped, host must not rely on them
		if (host_wr && hit(host_addr, `HMCB_OFF_MAC_DATA) && !busy_q) begin
			if (up) begin
				data_d[31:16] = host_wdata; // see RQ18
			end else begin
				data_d[15:0] = host_wdata; // see RQ18
			end
		end
		unique case (st_q)
			HMCB_IDLE: begin
				if (busy_q) begin
					st_d = HMCB_ISSUE;
				end
			end
			HMCB_ISSUE: begin
				st_d = HMCB_WAIT;
			end
			HMCB_WAIT: begin
				if (mac_done) begin
					if (dir_q) begin
						data_d = mac_rdata; // see RQ14
					end
					busy_d = 1'b0; // see RQ13
					st_d = HMCB_IDLE;
				end
			end
			default: begin
				st_d = HMCB_IDLE;
			end
		endcase
	end

	// read mux, registered; reserved bits come back as zero
	always_comb begin
		logic [31:0] w;
		w = `HMCB_RST_ZERO32;
		rdata_d = rdata_q;
		if (host_rd) begin
			unique case (host_addr & `HMCB_WORD_MASK)
				`HMCB_OFF_TIMER_COUNT: w = {`HMCB_ZERO16, timer_q}; // see RQ1
				`HMCB_OFF_WORD_ORDER: w = order_q;
				`HMCB_OFF_FREE_TICK: w = free_snap; // see RQ7
				`HMCB_OFF_RX_DISCARD: w = drop_lo_pend_q ? drop_snap_q : drop_q;
				`HMCB_OFF_MAC_CMD: w = {busy_q, dir_q, 22'h000000, caddr_q}; // see RQ19
				`HMCB_OFF_MAC_DATA: w = data_q;
				default: w = `HMCB_RST_ZERO32;
			endcase
			rdata_d = up ? w[31:16] : w[15:0];
		end
	end

	// network-side fifo word order ignores the host word order
	always_comb begin
		txw_d = tx_word_sel ? tx_fifo_entry[31:16] : tx_fifo_entry[15:0]; // see RQ5
		rxe_d = rxe_q;
		if (rx_word_valid) begin
			if (rx_first_word) begin
				rxe_d[15:0] = rx_net_word; // see RQ5
			end else begin
				rxe_d[31:16] = rx_net_word;
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			order_q <= `HMCB_RST_WORD_ORDER;
			timer_q <= `HMCB_RST_TIMER; // see RQ1
			wrap_q <= 1'b0;
			drop_q <= `HMCB_RST_ZERO32;
			drop_snap_q <= `HMCB_RST_ZERO32;
			drop_lo_pend_q <= 1'b0;
			half_ev_q <= 1'b0;
			busy_q <= 1'b0;
			dir_q <= 1'b0;
			caddr_q <= `HMCB_RST_ADDR8;
			data_q <= `HMCB_RST_ZERO32;
			st_q <= HMCB_IDLE;
			rdata_q <= `HMCB_ZERO16;
			txw_q <= `HMCB_ZERO16;
			rxe_q <= `HMCB_RST_ZERO32;
		end else begin
			order_q <= order_d;
			timer_q <= timer_d;
			wrap_q <= wrap_d;
			drop_q <= drop_d;
			drop_snap_q <= drop_snap_d;
			drop_lo_pend_q <= drop_lo_pend_d;
			half_ev_q <= half_ev_d;
			busy_q <= busy_d;
			dir_q <= dir_d;
			caddr_q <= caddr_d;
			data_q <= data_d;
			st_q <= st_d;
			rdata_q <= rdata_d;
			txw_q <= txw_d;
			rxe_q <= rxe_d;
		end
	end

	assign host_rdata = rdata_q;
	assign word_swap_upper = up;
	assign timer_wrap = wrap_q;
	assign rx_discard_half_event = half_ev_q;
	assign mac_req = (st_q == HMCB_ISSUE);
	assign mac_read_not_write = dir_q;
	assign mac_addr = caddr_q;
	assign mac_wdata = data_q;
	assign tx_net_word = txw_q;
	assign rx_fifo_entry = rxe_q;
endmodule

//--- sim/hmcb_mac_model.sv
// mac csr responder: a done pulse DLY cycles after each request
// assumes the command fields stand from request to done
`timescale 1ns/1ps
module hmcb_mac_model #(
	parameter int DLY = 4
) (
	input wire logic clk,
	input wire logic mac_req,
	input wire logic mac_read_not_write,
	input wire logic [7:0] mac_addr,
	input wire logic [31:0] mac_wdata,
	output logic mac_done,
	output logic [31:0] mac_rdata
);
	int cnt = 0;
	logic [31:0] held = 32'h00000000;
	initial mac_done = 1'b0;
	initial mac_rdata = 32'h00000000;
	// read data mixes in the address so a wrong address shows
	always @(posedge clk) begin
		mac_done <= 1'b0;
		if (cnt > 0)
			cnt <= cnt - 1;
		if (mac_req)
			cnt <= DLY;
		if (mac_req && !mac_read_not_write)
			held <= mac_wdata;
		if (cnt == 1) begin
			mac_done <= 1'b1;
			mac_rdata <= held ^ {4{mac_addr}};
		end else
			mac_rdata <= ~mac_rdata; // garbage outside done
	end
endmodule

//--- sim/hmcb_bank_asserts.sv
// port checker for the misc csr bank
// bound to the bank; sees its ports only
`timescale 1ns/1ps
module hmcb_bank_asserts (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] host_addr,
	input wire logic host_rd,
	input wire logic host_wr,
	input wire logic [15:0] host_wdata,
	input wire logic [15:0] host_rdata,
	input wire logic word_swap_upper,
	input wire logic mac_req,
	input wire logic mac_read_not_write,
	input wire logic [7:0] mac_addr,
	input wire logic [31:0] tx_fifo_entry,
	input wire logic [15:0] tx_net_word,
	input wire logic tx_word_sel,
	input wire logic [15:0] rx_net_word,
	input wire logic rx_first_word,
	input wire logic rx_word_valid
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// busy bit written in the upper command half starts an access
	sequence s_go;
		host_wr && word_swap_upper && host_addr[7:2] == 6'h29 && host_wdata[15];
	endsequence
	sequence s_issue;
		##2 mac_req;
	endsequence
	a_go_issues_req: assert property (s_go |-> s_issue)
		else $error("no mac request after start");
	a_dir_carried: assert property (s_go |-> ##2 mac_read_not_write == $past(host_wdata[14], 2))
		else $error("direction not carried");
	a_req_one_cycle: assert property (mac_req |=> !mac_req)
		else $error("mac request longer than one cycle");
	a_addr_holds: assert property (mac_req |=> $stable(mac_addr) [*2])
		else $error("mac address moved during access");
	a_rdata_stands: assert property (!host_rd |=> $stable(host_rdata))
		else $error("read data moved without a read");
	a_unmapped_zero: assert property (host_rd && host_addr[7:2] == 6'h25 |=> host_rdata == 16'h0000)
		else $error("unmapped read not zero");
	a_timer_upper_zero: assert property (host_rd && host_addr[7:2] == 6'h24 && word_swap_upper
		|=> host_rdata == 16'h0000)
		else $error("timer upper half not zero");
	a_tx_low_word: assert property (!tx_word_sel |=> tx_net_word == $past(tx_fifo_entry[15:0]))
		else $error("tx low word wrong");
	a_tx_high_word: assert property (tx_word_sel |=> tx_net_word == $past(tx_fifo_entry[31:16]))
		else $error("tx high word wrong");
endmodule
bind hmcb_host_misc_csr_bank hmcb_bank_asserts u_hmcb_bank_asserts (.clk, .sys_rst, .host_addr,
	.host_rd, .host_wr, .host_wdata, .host_rdata, .word_swap_upper, .mac_req, .mac_read_not_write,
	.mac_addr, .tx_fifo_entry, .tx_net_word, .tx_word_sel, .rx_net_word, .rx_first_word,
	.rx_word_valid);

//--- sim/hmcb_host_misc_csr_bank_tb_top.sv
// bench for the misc csr bank: host reads and writes with expected values
// inputs change on the falling edge; the mac side is hmcb_mac_model
`timescale 1ns/1ps
module hmcb_host_misc_csr_bank_tb_top;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic host_rd = 1'b0, host_wr = 1'b0, timer_load = 1'b0, timer_run = 1'b0;
	logic rx_frame_dropped = 1'b0, tx_word_sel = 1'b0, rx_first_word = 1'b0, rx_word_valid = 1'b0;
	logic [7:0] host_addr = 8'h00;
	logic [15:0] host_wdata = 16'h0000, timer_preload_value = 16'h1234, rx_net_word = 16'h0000;
	logic [31:0] tx_fifo_entry = 32'haaaa5555;
	logic word_swap_upper, timer_wrap, rx_discard_half_event, mac_req, mac_read_not_write, mac_done;
	logic [15:0] host_rdata, tx_net_word;
	logic [7:0] mac_addr;
	logic [31:0] mac_wdata, mac_rdata, rx_fifo_entry;
	int err_total = 0;
	int checks_done = 0;
	// the discard register is read in both halves so its snapshot pairing is closed
	logic [7:0] ra [9] = '{8'h90, 8'h92, 8'h98, 8'ha0, 8'ha2, 8'ha4, 8'ha6, 8'ha8, 8'h94};
	logic [15:0] re [9] = '{16'hffff, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
	hmcb_host_misc_csr_bank u_hmcb_host_misc_csr_bank (.clk, .sys_rst, .host_addr, .host_rd,
		.host_wr, .host_wdata, .host_rdata, .word_swap_upper, .timer_preload_value, .timer_load,
		.timer_run, .timer_wrap, .rx_frame_dropped, .rx_discard_half_event, .mac_req,
		.mac_read_not_write, .mac_addr, .mac_wdata, .mac_done, .mac_rdata, .tx_fifo_entry,
		.tx_net_word, .tx_word_sel, .rx_net_word, .rx_first_word, .rx_word_valid, .rx_fifo_entry);
	hmcb_mac_model #(.DLY(4)) u_hmcb_mac_model (.clk, .mac_req, .mac_read_not_write, .mac_addr,
		.mac_wdata, .mac_done, .mac_rdata);
	initial begin
		forever #20 clk = ~clk;
	end
	task automatic give_verdict();
		if (err_total == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one strobe cycle, then a quiet cycle so strobes never meet
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		host_addr = a;
		host_wdata = d;
		host_wr = 1'b1;
		@(negedge clk);
		host_wr = 1'b0;
		@(negedge clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] v);
		host_addr = a;
		host_rd = 1'b1;
		@(negedge clk);
		host_rd = 1'b0;
		repeat (2) @(negedge clk);
		v = host_rdata;
	endtask
	// busy is seen set, then must clear in a bounded number of polls
	task automatic poll();
		logic [15:0] v;
		rd(8'ha6, v);
		chk("busy set", {15'h0, v[15]}, 16'h1);
		repeat (20) if (v[15] === 1'b1) rd(8'ha6, v);
		chk("busy clear", {15'h0, v[15]}, 16'h0);
	endtask
	initial begin
		#(40 * 3000);
		err_total++;
		give_verdict();
	end
	initial begin
		logic [15:0] v, w;
		repeat (12) @(posedge clk);
		@(negedge clk);
		sys_rst = 1'b0;
		foreach (ra[i]) begin
			rd(ra[i], v);
			chk("reset value", v, re[i]);
		end
		timer_preload_value = 16'h4321;
		timer_load = 1'b1;
		@(negedge clk);
		timer_load = 1'b0;
		rd(8'h90, v);
		chk("timer preload", v, 16'h4321);
		rd(8'h9c, v);
		rd(8'h9e, w);
		chk("free upper", w, 16'h0000);
		rd(8'h9c, w);
		chk("free step", w - v, 16'd6);
		rx_frame_dropped = 1'b1;
		repeat (3) @(negedge clk);
		rx_frame_dropped = 1'b0;
		rd(8'ha0, v);
		chk("drop count", v, 16'h0003);
		rd(8'ha2, v);
		chk("drop upper", v, 16'h0000);
		rd(8'ha0, v);
		chk("drop cleared", v, 16'h0000);
		wr(8'h98, 16'hffff);
		wr(8'h9a, 16'hffff);
		rd(8'h92, v);
		chk("swapped low", v, 16'h4321);
		wr(8'h98, 16'h0000);
		wr(8'h92, 16'hffff);
		rd(8'h92, v);
		chk("upper after swap off", v, 16'h0000);
		rd(8'h90, v);
		chk("lower after swap off", v, 16'h4321);
		wr(8'ha8, 16'h5678);
		wr(8'haa, 16'h1234);
		wr(8'ha4, 16'hff42);
		wr(8'ha6, 16'h8000);
		poll();
		wr(8'ha6, 16'hc000);
		wr(8'ha4, 16'h0011);
		poll();
		rd(8'ha8, v);
		chk("mac data low", v, 16'h5678 ^ 16'h4242);
		rd(8'haa, v);
		chk("mac data high", v, 16'h1234 ^ 16'h4242);
		rd(8'ha4, v);
		chk("mac address", v, 16'h0042);
		rd(8'ha6, v);
		chk("mac direction", v, 16'h4000);
		chk("mac addr port", {8'h00, mac_addr}, 16'h0042);
		rx_net_word = 16'h1111;
		rx_first_word = 1'b1;
		rx_word_valid = 1'b1;
		@(negedge clk);
		rx_net_word = 16'h2222;
		rx_first_word = 1'b0;
		@(negedge clk);
		rx_word_valid = 1'b0;
		tx_word_sel = 1'b1;
		@(negedge clk);
		chk("rx first word", rx_fifo_entry[15:0], 16'h1111);
		chk("rx second word", rx_fifo_entry[31:16], 16'h2222);
		chk("tx high word", tx_net_word, 16'haaaa);
		// timer reload at zero: short preload so the wrap comes quickly
		timer_preload_value = 16'h0001;
		timer_load = 1'b1;
		@(negedge clk);
		timer_load = 1'b0;
		timer_run = 1'b1;
		@(negedge clk);
		chk("timer wrap early", {15'h0, timer_wrap}, 16'h0000);
		@(negedge clk);
		chk("timer wrap", {15'h0, timer_wrap}, 16'h0001);
		timer_run = 1'b0;
		rd(8'h90, v);
		chk("timer reload", v, 16'h0001);
		// mid-run reset, then a read at the very first edge after release
		sys_rst = 1'b1;
		@(negedge clk);
		sys_rst = 1'b0;
		rd(8'h9c, v);
		chk("free after reset", v, 16'h0000);
		give_verdict();
	end
endmodule
